/* hdl/sbg_top.sv */
// Baud generator and synchronous master transmitter with Avalon-MM slave
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
`include "sbg_regs.svh"
module sbg_top #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              arst_n_in,
    // Avalon-MM register slave
    input  wire sbg_pkg::sbg_avreq_s avs_req_in,
    output sbg_pkg::sbg_avrsp_s    avs_rsp_out,
    // Clock pin and two-way data pin
    output sbg_pkg::sbg_pin_s      clock_pin_out,
    input  wire logic              data_pin_in,
    output sbg_pkg::sbg_pin_s      data_pin_out
);
    import sbg_pkg::*;

    if (ADDR_W != 8) begin : g_bad_addr
        $error("sbg_top: ADDR_W must be 8");
    end

    typedef struct packed {
        sbg_ctrl_s   ctrl;
        logic [7:0]  div_lo;
        logic [7:0]  div_hi;
        logic [7:0]  hold;
        logic        hold_ninth;
        logic        hold_full;
        logic [8:0]  shift;
        logic [3:0]  bits_left;
        sbg_tx_e     tx_st;
        logic [4:0]  pre_cnt;
        logic [15:0] brg_cnt;
        logic        half_tick;
        logic        ck_out;
        logic        dt_out;
        logic        ack;
        logic [31:0] rdata;
        logic [1:0]  dt_sync;
    } sbg_state_s;

    sbg_state_s q;
    sbg_state_s d;

    logic        take;
    logic        commit;
    logic        div_wr;
    logic        tx_dir;
    logic        sync_cfg;
    logic [4:0]  pre_top;
    logic [15:0] reload;

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Waitrequest drops one cycle after a request appears; a write lands
    // only at the edge that ends the wait, where the master sees it done
    assign take = (avs_req_in.read | avs_req_in.write) & ~q.ack;
    assign commit = avs_req_in.write & q.ack;
    assign div_wr = commit &
                    (hit(avs_req_in.address, `SBG_OFS_DIVLO) |
                     hit(avs_req_in.address, `SBG_OFS_DIVHI));

    assign sync_cfg = q.ctrl.port_en & q.ctrl.sync_mode &
                      q.ctrl.clk_master;
    assign tx_dir = sync_cfg & q.ctrl.tx_en &
                    ~q.ctrl.srx_en & ~q.ctrl.crx_en;

    // Prescaler gives half the period multiplier
    always_comb begin
        if (q.ctrl.sync_mode) begin
            pre_top = `SBG_PRE_HIGH;
        end else if (q.ctrl.high_speed & q.ctrl.wide_sel) begin
            pre_top = `SBG_PRE_HIGH;
        end else if (q.ctrl.high_speed | q.ctrl.wide_sel) begin
            pre_top = `SBG_PRE_MID;
        end else begin
            pre_top = `SBG_PRE_LOW;
        end
    end

    // 8-bit mode ignores the high byte
    assign reload = q.ctrl.wide_sel ? {q.div_hi, q.div_lo}
                                    : {8'h00, q.div_lo};

    always_comb begin
        d = q;
        d.half_tick = 1'b0;
        d.dt_sync = {q.dt_sync[0], data_pin_in};
        d.ack = take;

        // Register writes
        if (commit) begin
            unique case (avs_req_in.address)
                `SBG_OFS_CTRL: begin
                    d.ctrl.port_en    = avs_req_in.writedata[0];
                    d.ctrl.sync_mode  = avs_req_in.writedata[1];
                    d.ctrl.clk_master = avs_req_in.writedata[2];
                    d.ctrl.tx_en      = avs_req_in.writedata[3];
                    d.ctrl.ninth_en   = avs_req_in.writedata[4];
                    d.ctrl.ninth_val  = avs_req_in.writedata[5];
                    d.ctrl.srx_en     = avs_req_in.writedata[6];
                    d.ctrl.crx_en     = avs_req_in.writedata[7];
                    d.ctrl.high_speed = avs_req_in.writedata[8];
                end
                `SBG_OFS_BAUD: begin
                    d.ctrl.wide_sel = avs_req_in.writedata[0];
                    d.ctrl.clk_pol  = avs_req_in.writedata[1];
                end
                `SBG_OFS_DIVLO: d.div_lo = avs_req_in.writedata[7:0];
                `SBG_OFS_DIVHI: d.div_hi = avs_req_in.writedata[7:0];
                default: ;
            endcase
        end

        // Register reads; the shift register has no address
        if (take && avs_req_in.read) begin
            d.rdata = 32'h0000_0000;
            unique case (avs_req_in.address)
                `SBG_OFS_CTRL: d.rdata[8:0] = {q.ctrl.high_speed,
                    q.ctrl.crx_en, q.ctrl.srx_en, q.ctrl.ninth_val,
                    q.ctrl.ninth_en, q.ctrl.tx_en, q.ctrl.clk_master,
                    q.ctrl.sync_mode, q.ctrl.port_en};
                // Receive path is absent, so the receiver is always idle
                `SBG_OFS_BAUD: d.rdata[2:0] = {1'b1, q.ctrl.clk_pol,
                                               q.ctrl.wide_sel};
                `SBG_OFS_DIVLO: d.rdata[7:0] = q.div_lo;
                `SBG_OFS_DIVHI: d.rdata[7:0] = q.div_hi;
                `SBG_OFS_STAT: d.rdata[3:0] = {q.ck_out, q.dt_sync[1],
                    q.tx_st == SBG_IDLE, ~q.hold_full};
                default: ;
            endcase
        end

        // Free running baud timer, cleared by any divisor write
        if (div_wr) begin
            d.pre_cnt = 5'h00;
            d.brg_cnt = 16'h0000;
        end else if (q.pre_cnt >= pre_top) begin
            d.pre_cnt = 5'h00;
            if (q.brg_cnt >= reload) begin
                d.brg_cnt = 16'h0000;
                d.half_tick = 1'b1;
            end else begin
                d.brg_cnt = q.brg_cnt + 16'h0001;
            end
        end else begin
            d.pre_cnt = q.pre_cnt + 5'h01;
        end

        // Holding register; a fresh write wins over the move out
        if (commit && hit(avs_req_in.address, `SBG_OFS_HOLD)) begin
            d.hold = avs_req_in.writedata[7:0];
            d.hold_ninth = q.ctrl.ninth_val;
            d.hold_full = 1'b1;
        end

        // Synchronous master transmit sequencer
        unique case (q.tx_st)
            SBG_IDLE: begin
                d.ck_out = q.ctrl.clk_pol;
                if (q.hold_full && tx_dir) begin
                    d.shift = {q.hold_ninth, q.hold};
                    d.bits_left = q.ctrl.ninth_en ? `SBG_BITS_9
                                                  : `SBG_BITS_8;
                    if (!(commit &&
                          hit(avs_req_in.address, `SBG_OFS_HOLD))) begin
                        d.hold_full = 1'b0;
                    end
                    d.tx_st = SBG_LEAD;
                end
            end
            SBG_LEAD: begin
                if (q.half_tick) begin
                    d.ck_out = ~q.ctrl.clk_pol;
                    d.dt_out = q.shift[0];
                    d.shift = {1'b0, q.shift[8:1]};
                    d.bits_left = q.bits_left - 4'h1;
                    d.tx_st = SBG_TRAIL;
                end
            end
            SBG_TRAIL: begin
                if (q.half_tick) begin
                    d.ck_out = q.ctrl.clk_pol;
                    // Next character only after the last bit left
                    if (q.bits_left == 4'h0) begin
                        d.tx_st = SBG_IDLE;
                    end else begin
                        d.tx_st = SBG_LEAD;
                    end
                end
            end
        endcase

        // Leaving transmit direction drops the character in flight
        if (!tx_dir) begin
            d.tx_st = SBG_IDLE;
            d.ck_out = q.ctrl.clk_pol;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            q <= '0;
            q.ctrl <= `SBG_RST_CTRL;
            q.div_lo <= `SBG_RST_DIV;
            q.div_hi <= `SBG_RST_DIV;
            q.tx_st <= SBG_IDLE;
        end else begin
            q <= d;
        end
    end

    assign avs_rsp_out.readdata = q.rdata;
    assign avs_rsp_out.waitrequest = (avs_req_in.read |
                                      avs_req_in.write) & ~q.ack;
    // Idle clock level still follows polarity while the driver is on
    assign clock_pin_out.out = q.ck_out;
    assign clock_pin_out.oe = sync_cfg;
    assign data_pin_out.out = q.dt_out;
    assign data_pin_out.oe = tx_dir;

    // Checks
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    sequence s_div_wr;
        div_wr;
    endsequence

    sequence s_lead_edge;
        q.tx_st == SBG_LEAD && q.half_tick;
    endsequence

    chk_div_clear: assert property (
        s_div_wr |=> q.brg_cnt == 16'h0000 && q.pre_cnt == 5'h00)
        else $error("divisor write did not clear baud timer");

    chk_brg_wrap: assert property (
        !div_wr && q.pre_cnt == pre_top && q.brg_cnt == reload
        |=> q.half_tick && q.brg_cnt == 16'h0000)
        else $error("baud timer did not wrap at reload");

    chk_narrow_gen: assert property (
        !q.ctrl.wide_sel |-> reload[15:8] == 8'h00)
        else $error("8-bit generator used high divisor byte");

    chk_sync_mult: assert property (
        q.ctrl.sync_mode |-> pre_top == `SBG_PRE_HIGH)
        else $error("sync mode did not ignore high speed bit");

    chk_async_low: assert property (
        !q.ctrl.sync_mode && !q.ctrl.high_speed && !q.ctrl.wide_sel
        |-> pre_top == `SBG_PRE_LOW)
        else $error("async low speed multiplier is not 64");

    chk_clk_driver: assert property (
        clock_pin_out.oe == (q.ctrl.port_en && q.ctrl.sync_mode &&
                             q.ctrl.clk_master))
        else $error("clock pin driver state wrong");

    chk_data_dir: assert property (
        data_pin_out.oe |-> !q.ctrl.srx_en && !q.ctrl.crx_en)
        else $error("data driven while receive enabled");

    chk_idle_level: assert property (
        q.tx_st == SBG_IDLE |=> q.ck_out == $past(q.ctrl.clk_pol))
        else $error("clock idle level does not follow polarity");

    chk_lead_data: assert property (
        (s_lead_edge and tx_dir) |=> q.ck_out != q.ctrl.clk_pol &&
        q.dt_out == $past(q.shift[0]))
        else $error("data did not change on leading edge");

    chk_data_hold: assert property (
        q.tx_st == SBG_TRAIL && $past(q.tx_st) == SBG_TRAIL
        |-> $stable(q.dt_out))
        else $error("data moved before next leading edge");

    chk_load_now: assert property (
        q.tx_st == SBG_IDLE && q.hold_full && tx_dir
        |=> q.tx_st == SBG_LEAD)
        else $error("character not moved into empty shift register");

    chk_bit_count: assert property (
        q.tx_st == SBG_TRAIL && q.half_tick && q.bits_left == 4'h0
        && tx_dir |=> q.tx_st == SBG_IDLE)
        else $error("extra clock pulse after last bit");

endmodule : sbg_top

/* hdl/sbg_regs.svh */
// Register map, field positions and reset values of the serial port
// Functional notes
// - Baud generator is 8-bit after reset, 16-bit when wide select set.
// - Divisor byte pair is the reload value setting the baud timer period.
// - Async multiplier chosen by high-speed bit and wide select together.
// - Synchronous mode ignores the high-speed bit.
// - Async 8-bit low-speed rate is clock over 64 times divisor plus one.
// - Writing either divisor byte clears the baud timer at once.
// - One clock line, one two-way data line, never send and receive together.
// - Clocked mode sends no start or stop bits.
// - Sync select makes the port synchronous; clock source makes it master.
// - Master transmits only while both receive enables are clear.
// - Port works only while its port enable bit is set.
// - Master drives bit clock; clock pin driver on whenever sync configured.
// - Data changes on leading edge, held through trailing edge.
// - Exactly one clock pulse per data bit, none extra.
// - Polarity set: idle high, change on fall; clear: idle low, on rise.
// - Transmit data leaves on data pin; data and clock drivers enabled.
// - Holding write starts transfer; moves at once into empty shift register.
// - New character waits in holding register until previous last bit sent.
// - Shift register is not reachable by software.
`ifndef SBG_REGS_SVH
`define SBG_REGS_SVH
`define SBG_OFS_CTRL   8'h00
`define SBG_OFS_BAUD   8'h04
`define SBG_OFS_DIVLO  8'h08
`define SBG_OFS_DIVHI  8'h0c
`define SBG_OFS_HOLD   8'h10
`define SBG_OFS_STAT   8'h14
`define SBG_RST_DIV    8'h00
`define SBG_RST_CTRL   11'h000
`define SBG_BIT_NINTH  8
`define SBG_PRE_LOW    5'h1f
`define SBG_PRE_MID    5'h07
`define SBG_PRE_HIGH   5'h01
`define SBG_BITS_8     4'h8
`define SBG_BITS_9     4'h9
`endif

/* hdl/sbg_pkg.sv */
// Types shared by the serial baud generator and synchronous transmitter
package sbg_pkg;
    typedef struct packed {
        logic clk_pol;
        logic wide_sel;
        logic high_speed;
        logic crx_en;
        logic srx_en;
        logic ninth_val;
        logic ninth_en;
        logic tx_en;
        logic clk_master;
        logic sync_mode;
        logic port_en;
    } sbg_ctrl_s;

    typedef enum logic [1:0] {SBG_IDLE, SBG_LEAD, SBG_TRAIL} sbg_tx_e;

    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } sbg_avreq_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } sbg_avrsp_s;

    typedef struct packed {
        logic out;
        logic oe;
    } sbg_pin_s;
endpackage : sbg_pkg

/* tb/sbg_slave_model.sv */
// Slave receiver model that watches the clock and data pins
`timescale 1ns/10ps
module sbg_slave_model (
    // Clock
    input  wire logic              sys_clk_in,
    // Pins seen from the slave side
    input  wire logic              clk_pol_in,
    input  wire sbg_pkg::sbg_pin_s clock_pin_in,
    input  wire sbg_pkg::sbg_pin_s data_pin_in,
    output logic                   data_drv_out
);
    import sbg_pkg::*;
    logic prev_q;
    logic last_q;
    int   gap;
    logic bits_q[$];
    int   gaps_q[$];
    initial begin
        prev_q = 1'b0;
        last_q = 1'b0;
        gap    = 0;
    end
    // No pull on the line, so a released pin shows the inverse level
    assign data_drv_out = data_pin_in.oe ? data_pin_in.out : ~last_q;
    always @(posedge sys_clk_in) begin
        gap    <= gap + 1;
        prev_q <= clock_pin_in.out;
        if (data_pin_in.oe) last_q <= data_pin_in.out;
        if (clock_pin_in.out != prev_q) begin
            // Trailing edge returns to idle level: take the bit there
            if (clock_pin_in.out == clk_pol_in) begin
                bits_q.push_back(data_pin_in.out);
            end else begin
                gaps_q.push_back(gap);
                gap <= 1;
            end
        end
    end
endmodule : sbg_slave_model

/* tb/sbg_top_tb.sv */
// Self-checking bench of the baud generator and synchronous transmitter
`timescale 1ns/10ps
`include "sbg_regs.svh"
module sbg_top_tb;
    import sbg_pkg::*;
    logic        sys_clk;
    logic        arst_n;
    sbg_avreq_s  req;
    sbg_avrsp_s  rsp;
    sbg_pin_s    clk_pin;
    sbg_pin_s    dat_pin;
    logic        dat_in;
    logic        pol;
    logic [7:0]  lfsr_q;
    logic [31:0] rd;
    logic        exp_q[$];
    int          miscompares;
    int          checks_done;
    int          cycles;
    sbg_top u_sbg_top (.sys_clk_in(sys_clk), .arst_n_in(arst_n),
        .avs_req_in(req), .avs_rsp_out(rsp), .clock_pin_out(clk_pin),
        .data_pin_in(dat_in), .data_pin_out(dat_pin));
    sbg_slave_model u_sbg_slave_model (.sys_clk_in(sys_clk),
        .clk_pol_in(pol), .clock_pin_in(clk_pin), .data_pin_in(dat_pin),
        .data_drv_out(dat_in));
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t register got %h want %h", $time, got, exp);
        end
    endtask : cmp_reg
    task automatic cmp_ser(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t serial got %0d want %0d", $time, got, exp);
        end
    endtask : cmp_ser
    // Request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        req.address   <= a;
        req.write     <= w;
        req.read      <= ~w;
        req.writedata <= d;
        do @(posedge sys_clk); while (rsp.waitrequest !== 1'b0);
        q = rsp.readdata;
        req.read  <= 1'b0;
        req.write <= 1'b0;
    endtask : bus
    task automatic send(input logic p, input logic wide, input logic n9,
                        input logic hs, input logic [7:0] lo,
                        input logic [7:0] hi);
        int nb;
        int per;
        logic [31:0] ctl;
        nb  = n9 ? 9 : 8;
        per = 4 * ((wide ? {hi, lo} : lo) + 1);
        ctl = {23'h0, hs, 2'b00, lfsr_q[0], n9, 4'hf};
        pol = p;
        bus(1, `SBG_OFS_BAUD, {30'h0, p, wide}, rd);
        bus(1, `SBG_OFS_DIVLO, {24'h0, lo}, rd);
        bus(1, `SBG_OFS_DIVHI, {24'h0, hi}, rd);
        bus(1, `SBG_OFS_CTRL, ctl, rd);
        u_sbg_slave_model.bits_q.delete();
        u_sbg_slave_model.gaps_q.delete();
        exp_q.delete();
        repeat (2) begin
            lfsr_q = lfsr_next(lfsr_q);
            for (int i = 0; i < 8; i++) exp_q.push_back(lfsr_q[i]);
            if (n9) exp_q.push_back(ctl[5]);
            bus(1, `SBG_OFS_HOLD, {24'h0, lfsr_q}, rd);
        end
        do bus(0, `SBG_OFS_STAT, 0, rd); while (rd[1:0] !== 2'b11);
        cmp_ser(u_sbg_slave_model.bits_q.size(), 2 * nb);
        foreach (exp_q[i]) cmp_ser(u_sbg_slave_model.bits_q[i], exp_q[i]);
        // Second character follows back to back at the same bit period
        for (int i = 1; i < 2 * nb; i++)
            cmp_ser(u_sbg_slave_model.gaps_q[i], per);
        cmp_reg({clk_pin.out, clk_pin.oe, dat_pin.oe}, {p, 2'b11});
    endtask : send
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Longest case is about twenty thousand cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        arst_n = 1'b0;
        req = '0;
        pol = 1'b0;
        lfsr_q = 8'h14;
        miscompares = 0;
        checks_done = 0;
        cycles = 0;
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        bus(0, `SBG_OFS_CTRL, 0, rd);
        cmp_reg(rd, 32'h0);
        bus(0, `SBG_OFS_BAUD, 0, rd);
        cmp_reg(rd, 32'h4);
        cmp_reg({clk_pin.oe, dat_pin.oe}, 2'b00);
        send(0, 0, 0, 0, 8'h01, 8'h05);
        send(1, 0, 1, 1, 8'h00, 8'h00);
        send(0, 1, 1, 0, 8'h02, 8'h01);
        bus(1, `SBG_OFS_CTRL, 32'h47, rd);
        repeat (2) @(posedge sys_clk);
        cmp_reg({clk_pin.oe, dat_pin.oe}, 2'b10);
        bus(1, `SBG_OFS_CTRL, 32'h8e, rd);
        repeat (2) @(posedge sys_clk);
        cmp_reg({clk_pin.oe, dat_pin.oe}, 2'b00);
        bus(0, `SBG_OFS_HOLD, 0, rd);
        cmp_reg(rd, 32'h0);
        bus(0, 8'h20, 0, rd);
        cmp_reg(rd, 32'h0);
        bus(1, `SBG_OFS_STAT, 32'h0, rd);
        bus(0, `SBG_OFS_STAT, 0, rd);
        // Released data line shows the inverse of the last bit sent
        cmp_reg(rd[3:0], {1'b0, ~exp_q[$], 2'b11});
        conclude();
    end
endmodule : sbg_top_tb
